// ---- hw/xpt_ctrl_host.sv ----
// Host sequencer driving the crosspoint switch level-sensitive control pins
`timescale 1ns/1ns
// Function
// [RULE1] Address picks output 0..16, low six data bits pick input 0..32, binary.
// [RULE2] Enable bit one enables the addressed output when the word takes effect.
// [RULE3] Enable bit zero disables the addressed output; input code ignored.
// [RULE4] Broadcast address writes code and enable bit into all 17 outputs.
// [RULE5] Readback at broadcast address gives no meaningful data.
// [RULE6] Never use addresses above broadcast or input codes above 32.
// [RULE7] Write strobe held low at least 15 ns per write.
// [RULE8] Update strobe held low at least 15 ns for rank transfer.
// [RULE9] At least 10 ns between write strobe and following update strobe.
// [RULE10] Device enables newly enabled outputs within 40 ns of update.
// [RULE11] Device disables newly disabled outputs within 30 ns of update.
// [RULE12] Combined mode reconnects addressed output within 30 ns of write strobe.
// [RULE13] Combined mode enables addressed output within 40 ns of write strobe.
// [RULE14] Readback drives stored second-rank word, typically 15 ns after strobe.
// [RULE15] Reset input held low at least 15 ns for global disable.
// [RULE16] Device disables all outputs within 30 ns of reset going low.
// [RULE17] Reset low clears every second-rank enable bit regardless of other pins.
// [RULE18] Chip select high: inputs ignored, data pins released, matrix kept.
// [RULE19] Select, write low, update high stores word in addressed first rank.
// [RULE20] Select and update low copy all first ranks into second rank.
// [RULE21] Control inputs are level sensitive; latches transparent while strobed.
module xpt_ctrl_host
  import xpt_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  // Command port
  input  wire logic              cmd_valid,
  input  wire logic [2:0]        cmd_op,
  input  wire logic [ADDR_W-1:0] cmd_addr,
  input  wire logic [CODE_W-1:0] cmd_code,
  input  wire logic              cmd_enable,
  output logic                   cmd_ready,
  output logic                   cmd_done,
  output logic                   cmd_error,
  output logic [DATA_W-1:0]      rd_data,
  // Device control pins
  output logic                   chip_sel_n,
  output logic                   first_rank_wr_n,
  output logic                   rank_update_n,
  output logic                   second_rank_query_n,
  output logic                   matrix_reset_n,
  output logic [ADDR_W-1:0]      out_addr,
  // Data pins
  input  wire logic [DATA_W-1:0] data_i,
  output logic [DATA_W-1:0]      data_o,
  output logic                   data_oe
);

  typedef enum logic [3:0] {
    ST_IDLE, ST_SETUP, ST_WR, ST_GAP, ST_UPD, ST_RD, ST_REL, ST_RST, ST_SETTLE
  } state_e;

  // ------------------------------------------------------------
  // Command check
  // ------------------------------------------------------------
  wire logic addr_bad  = (cmd_addr > BCAST_ADDR);                  // RULE6
  wire logic code_bad  = cmd_enable && (cmd_code > IN_MAX);        // RULE6 RULE3
  wire logic read_bad  = (cmd_op == CMD_READ) && (cmd_addr >= BCAST_ADDR); // RULE5
  wire logic op_bad    = (cmd_op > CMD_RESET);
  wire logic uses_addr = (cmd_op != CMD_UPDATE) && (cmd_op != CMD_RESET);
  wire logic cmd_bad   = op_bad || (uses_addr && (addr_bad || read_bad))
                         || (((cmd_op == CMD_WRITE) || (cmd_op == CMD_WR_UPD)) && code_bad);
  wire logic cmd_take  = cmd_valid && cmd_ready;

  // ------------------------------------------------------------
  // Read data pin synchroniser, three stages
  // ------------------------------------------------------------
  logic [DATA_W-1:0] rd_s1_reg, rd_s2_reg, rd_s3_reg;
  always_ff @(posedge ref_clk) begin
    rd_s1_reg <= data_i;
    rd_s2_reg <= rd_s1_reg;
    rd_s3_reg <= rd_s2_reg;
  end
  wire logic rd_stable = (rd_s2_reg == rd_s3_reg);

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  state_e           state_reg;
  logic [2:0]       op_reg;
  logic [CNT_W-1:0] cnt_reg;

  wire logic cnt_zero = (cnt_reg == '0);
  wire logic [CNT_W-1:0] cnt_dec = cnt_reg - 4'h1;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_reg           <= ST_IDLE;
      op_reg              <= CMD_WRITE;
      cnt_reg             <= '0;
      cmd_ready           <= 1'b0;
      cmd_done            <= 1'b0;
      cmd_error           <= 1'b0;
      rd_data             <= '0;
      chip_sel_n          <= 1'b1;
      first_rank_wr_n     <= 1'b1;
      rank_update_n       <= 1'b1;
      second_rank_query_n <= 1'b1;
      matrix_reset_n      <= 1'b1;
      out_addr            <= '0;
      data_o              <= '0;
      data_oe             <= 1'b0;
    end else begin
      cmd_done  <= 1'b0;
      cmd_error <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          cmd_ready  <= 1'b1;
          chip_sel_n <= 1'b1;   // RULE18
          data_oe    <= 1'b0;
          if (cmd_take) begin
            cmd_ready <= 1'b0;
            if (cmd_bad) begin
              cmd_error <= 1'b1;
              cmd_done  <= 1'b1;
              state_reg <= ST_SETTLE;
              cnt_reg   <= '0;
            end else begin
              op_reg    <= cmd_op;
              out_addr  <= cmd_addr;                                // RULE1
              data_o    <= {cmd_enable, cmd_code};                  // RULE1 RULE2 RULE3 RULE4
              if (cmd_op == CMD_RESET) begin
                matrix_reset_n <= 1'b0;                             // RULE15 RULE17
                cnt_reg        <= CNT_W'(RST_CYC - 1);
                state_reg      <= ST_RST;
              end else begin
                chip_sel_n <= 1'b0;
                data_oe    <= (cmd_op == CMD_WRITE) || (cmd_op == CMD_WR_UPD);
                state_reg  <= ST_SETUP;
              end
            end
          end
        end
        // Data settles one cycle before the write, update or query strobe falls
        ST_SETUP: begin
          if (op_reg == CMD_UPDATE) begin
            rank_update_n <= 1'b0;                                  // RULE20
            cnt_reg       <= CNT_W'(UPD_CYC - 1);
            state_reg     <= ST_UPD;
          end else if (op_reg == CMD_READ) begin
            second_rank_query_n <= 1'b0;                            // RULE14
            cnt_reg             <= CNT_W'(RD_CYC + 1);
            state_reg           <= ST_RD;
          end else begin
            first_rank_wr_n <= 1'b0;                                // RULE19 RULE21
            if (op_reg == CMD_WR_UPD)
              rank_update_n <= 1'b0;                                // RULE12 RULE13
            cnt_reg   <= CNT_W'(WR_CYC - 1);
            state_reg <= ST_WR;
          end
        end
        ST_WR: begin
          if (cnt_zero) begin
            first_rank_wr_n <= 1'b1;                                // RULE7
            rank_update_n   <= 1'b1;
            cnt_reg         <= CNT_W'(GAP_CYC - 1);
            state_reg       <= ST_GAP;
          end else begin
            cnt_reg <= cnt_dec;
          end
        end
        // Spacing after the write strobe before any later update
        ST_GAP: begin
          if (cnt_zero) begin
            data_oe <= 1'b0;
            cnt_reg <= (op_reg == CMD_WR_UPD) ? CNT_W'(SET_CYC - 1) : '0;  // RULE9
            state_reg <= ST_SETTLE;
          end else begin
            cnt_reg <= cnt_dec;
          end
        end
        ST_UPD: begin
          if (cnt_zero) begin
            rank_update_n <= 1'b1;                                  // RULE8
            cnt_reg       <= CNT_W'(SET_CYC - 1);                   // RULE10 RULE11
            state_reg     <= ST_SETTLE;
          end else begin
            cnt_reg <= cnt_dec;
          end
        end
        // Wait access time plus the synchroniser, then take a stable word
        ST_RD: begin
          if (cnt_zero && rd_stable) begin
            rd_data             <= rd_s3_reg;
            second_rank_query_n <= 1'b1;
            cnt_reg             <= CNT_W'(REL_CYC - 1);
            state_reg           <= ST_REL;
          end else if (!cnt_zero) begin
            cnt_reg <= cnt_dec;
          end
        end
        // Device may drive the data pins up to its release time
        ST_REL: begin
          if (cnt_zero) begin
            state_reg <= ST_SETTLE;
            cnt_reg   <= '0;
          end else begin
            cnt_reg <= cnt_dec;
          end
        end
        ST_RST: begin
          if (cnt_zero) begin
            matrix_reset_n <= 1'b1;
            cnt_reg        <= CNT_W'(SET_CYC - 1);                  // RULE16
            state_reg      <= ST_SETTLE;
          end else begin
            cnt_reg <= cnt_dec;
          end
        end
        ST_SETTLE: begin
          chip_sel_n <= 1'b1;
          if (cnt_zero) begin
            if (!cmd_error)
              cmd_done <= 1'b1;
            state_reg <= ST_IDLE;
          end else begin
            cnt_reg <= cnt_dec;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

endmodule : xpt_ctrl_host

// ---- hw/xpt_ctrl_pkg.sv ----
// Constants for the crosspoint control-port host sequencer
package xpt_ctrl_pkg;
  // ------------------------------------------------------------
  // Field widths and codes
  // ------------------------------------------------------------
  localparam int          ADDR_W        = 5;
  localparam int          DATA_W        = 7;
  localparam int          CODE_W        = 6;
  localparam int          EN_POS        = 6;
  localparam logic [4:0]  OUT_MAX       = 5'h10;
  localparam logic [4:0]  BCAST_ADDR    = 5'h11;
  localparam logic [5:0]  IN_MAX        = 6'h20;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 8;
  localparam int WR_PULSE_NS    = 15;
  localparam int UPD_PULSE_NS   = 15;
  localparam int WR_TO_UPD_NS   = 10;
  localparam int RST_PULSE_NS   = 15;
  localparam int RD_ACCESS_NS   = 15;
  localparam int RD_RELEASE_NS  = 30;
  localparam int UPD_SETTLE_NS  = 40;
  localparam int WR_CYC   = (WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int UPD_CYC  = (UPD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_CYC  = (WR_TO_UPD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CYC  = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RD_CYC   = (RD_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REL_CYC  = (RD_RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SET_CYC  = (UPD_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W    = 4;
  // ------------------------------------------------------------
  // Commands
  // ------------------------------------------------------------
  localparam logic [2:0] CMD_WRITE   = 3'h0;
  localparam logic [2:0] CMD_UPDATE  = 3'h1;
  localparam logic [2:0] CMD_WR_UPD  = 3'h2;
  localparam logic [2:0] CMD_READ    = 3'h3;
  localparam logic [2:0] CMD_RESET   = 3'h4;
endpackage : xpt_ctrl_pkg

// ---- dv/xpt_ctrl_host_chk.sv ----
// Pin protocol checker for the crosspoint host sequencer
`timescale 1ns/1ns
module xpt_ctrl_host_chk
  import xpt_ctrl_pkg::*;
(
  // Clock, reset and command port
  input wire logic              ref_clk,
  input wire logic              sys_rst,
  input wire logic              cmd_valid,
  input wire logic [2:0]        cmd_op,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [CODE_W-1:0] cmd_code,
  input wire logic              cmd_enable,
  input wire logic              cmd_ready,
  input wire logic              cmd_done,
  input wire logic              cmd_error,
  // Device pins
  input wire logic              chip_sel_n,
  input wire logic              first_rank_wr_n,
  input wire logic              rank_update_n,
  input wire logic              second_rank_query_n,
  input wire logic              matrix_reset_n,
  input wire logic [ADDR_W-1:0] out_addr,
  input wire logic [DATA_W-1:0] data_o,
  input wire logic              data_oe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  wire take  = cmd_valid && cmd_ready;
  wire is_wr = cmd_op == CMD_WRITE || cmd_op == CMD_WR_UPD;
  wire bad   = cmd_op > CMD_RESET || (is_wr && cmd_addr > BCAST_ADDR)
            || (cmd_op == CMD_READ && cmd_addr >= BCAST_ADDR)
            || (is_wr && cmd_enable && cmd_code > IN_MAX);
  sequence take_wr_s;
    take && cmd_op == CMD_WRITE && !bad;
  endsequence
  wr_pulse_a: assert property ($fell(first_rank_wr_n) |=> !first_rank_wr_n)
    else $error("write strobe too short");
  upd_pulse_a: assert property ($fell(rank_update_n) |=> !rank_update_n)
    else $error("update strobe too short");
  rst_pulse_a: assert property ($fell(matrix_reset_n) |=> !matrix_reset_n)
    else $error("matrix reset too short");
  wr_upd_gap_a: assert property ($rose(first_rank_wr_n) && rank_update_n |=> rank_update_n)
    else $error("update too soon after write");
  addr_range_a: assert property (!first_rank_wr_n || !second_rank_query_n |-> !chip_sel_n && out_addr <= BCAST_ADDR)
    else $error("strobe with bad address");
  code_range_a: assert property (!first_rank_wr_n && data_o[EN_POS] |-> data_oe && data_o[CODE_W-1:0] <= IN_MAX)
    else $error("write of bad input code");
  read_bcast_a: assert property (!second_rank_query_n |-> out_addr != BCAST_ADDR && !data_oe)
    else $error("bad readback cycle");
  refuse_bad_a: assert property (take && bad |-> chip_sel_n throughout (##[1:2] (cmd_done && cmd_error)))
    else $error("bad command not refused");
  write_word_a: assert property (take_wr_s |=> ##1 out_addr == $past(cmd_addr, 2) && data_oe
      && data_o == {$past(cmd_enable, 2), $past(cmd_code, 2)})
    else $error("wrong word on pins");
endmodule : xpt_ctrl_host_chk
bind xpt_ctrl_host xpt_ctrl_host_chk xpt_ctrl_host_chk_inst (.*);

// ---- dv/xpt_dev_model.sv ----
// Behavioural model of the crosspoint control port
`timescale 1ns/1ns
module xpt_dev_model
  import xpt_ctrl_pkg::*;
#(
  parameter int RD_DLY = 12
)(
  // Control pins
  input  wire logic                 chip_sel_n,
  input  wire logic                 first_rank_wr_n,
  input  wire logic                 rank_update_n,
  input  wire logic                 second_rank_query_n,
  input  wire logic                 matrix_reset_n,
  input  wire logic [ADDR_W-1:0]    out_addr,
  // Data pins and the second rank the matrix follows
  input  wire logic [DATA_W-1:0]    data_bus,
  output logic [DATA_W-1:0]         data_drv,
  output logic [16:0][DATA_W-1:0]   rank2
);
  logic [16:0][DATA_W-1:0] rank1;
  logic [DATA_W-1:0]       last_rd;
  wire sel_rd = matrix_reset_n && !chip_sel_n && !second_rank_query_n;
  // Latches are transparent while strobed, no clock anywhere
  always @* begin
    if (!matrix_reset_n) begin
      for (int i = 0; i < 17; i++) rank2[i][EN_POS] = 1'h0;
    end else if (!chip_sel_n) begin
      if (!first_rank_wr_n) begin
        for (int i = 0; i < 17; i++) if (out_addr == BCAST_ADDR || out_addr == 5'(i)) rank1[i] = data_bus;
      end
      if (!rank_update_n) rank2 = rank1;
    end
    if (sel_rd && out_addr <= OUT_MAX) last_rd = rank2[out_addr];
  end
  // Released pins show the inverse of the last read word, never a stale copy
  assign #RD_DLY data_drv = sel_rd && out_addr <= OUT_MAX ? rank2[out_addr] : ~last_rd;
endmodule : xpt_dev_model

// ---- dv/testbench.sv ----
// Self-checking bench for the crosspoint host sequencer
`timescale 1ns/1ns
module testbench;
  import xpt_ctrl_pkg::*;
  typedef struct packed {
    logic [2:0] op; logic [4:0] addr; logic [5:0] code; logic en; logic err;
  } row_s;
  logic                    ref_clk, sys_rst, cmd_valid, cmd_enable, cmd_ready, cmd_done, cmd_error;
  logic                    chip_sel_n, first_rank_wr_n, rank_update_n, second_rank_query_n;
  logic                    matrix_reset_n, data_oe;
  logic [2:0]              cmd_op;
  logic [ADDR_W-1:0]       cmd_addr, out_addr;
  logic [CODE_W-1:0]       cmd_code;
  logic [DATA_W-1:0]       rd_data, data_o, data_drv;
  logic [16:0][DATA_W-1:0] rank2, exp1, exp2;
  wire  [DATA_W-1:0]       data_bus = data_oe ? data_o : data_drv;
  int                      miscompares, compares, cycles;
  row_s rows [18] = '{
    '{CMD_WRITE, 5'h11, 6'h07, 1'h1, 1'h0}, '{CMD_WRITE, 5'h10, 6'h20, 1'h1, 1'h0},
    '{CMD_UPDATE, 5'h00, 6'h00, 1'h0, 1'h0}, '{CMD_READ, 5'h10, 6'h00, 1'h0, 1'h0},
    '{CMD_READ, 5'h00, 6'h00, 1'h0, 1'h0}, '{CMD_WR_UPD, 5'h03, 6'h00, 1'h0, 1'h0},
    '{CMD_READ, 5'h03, 6'h00, 1'h0, 1'h0}, '{CMD_WRITE, 5'h12, 6'h00, 1'h0, 1'h1},
    '{CMD_WRITE, 5'h01, 6'h21, 1'h1, 1'h1}, '{CMD_READ, 5'h11, 6'h00, 1'h0, 1'h1},
    '{3'h5, 5'h00, 6'h00, 1'h0, 1'h1}, '{CMD_WRITE, 5'h05, 6'h21, 1'h0, 1'h0},
    '{CMD_UPDATE, 5'h00, 6'h00, 1'h0, 1'h0}, '{CMD_RESET, 5'h00, 6'h00, 1'h0, 1'h0},
    '{CMD_READ, 5'h10, 6'h00, 1'h0, 1'h0}, '{CMD_READ, 5'h05, 6'h00, 1'h0, 1'h0},
    '{CMD_WR_UPD, 5'h11, 6'h1f, 1'h1, 1'h0}, '{CMD_READ, 5'h0c, 6'h00, 1'h0, 1'h0}};
  xpt_ctrl_host xpt_ctrl_host_inst (.*, .data_i(data_bus));
  // Readback delay kept at the typical access time the host counts on
  xpt_dev_model #(.RD_DLY(15)) xpt_dev_model_inst (.*);
  initial begin
    ref_clk = 1'h0;
    forever #4 ref_clk = ~ref_clk;
  end
  // ------------------------------------------------------------
  // Checking and command tasks
  // ------------------------------------------------------------
  task automatic check(input logic [118:0] got, input logic [118:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic run_cmd(input row_s r);
    int n;
    for (n = 0; n < 100 && cmd_ready !== 1'h1; n++) @(negedge ref_clk);
    check(cmd_ready, 1'h1);
    {cmd_op, cmd_addr, cmd_code, cmd_enable} = {r.op, r.addr, r.code, r.en};
    cmd_valid = 1'h1;
    @(negedge ref_clk);
    cmd_valid = 1'h0;
    for (n = 0; n < 100 && cmd_done !== 1'h1; n++) @(negedge ref_clk);
    check(cmd_done, 1'h1);
    check(cmd_error, r.err);
    if (r.err) return;
    for (int i = 0; i < 17; i++) begin
      if ((r.op == CMD_WRITE || r.op == CMD_WR_UPD) && (r.addr == BCAST_ADDR || r.addr == 5'(i)))
        exp1[i] = {r.en, r.code};
      if (r.op == CMD_RESET) exp2[i][EN_POS] = 1'h0;
    end
    if (r.op == CMD_UPDATE || r.op == CMD_WR_UPD) exp2 = exp1;
    if (r.op == CMD_READ) check(rd_data, exp2[r.addr]);
    if (!$isunknown(exp2)) check(rank2, exp2);
  endtask : run_cmd
  task automatic print_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      print_verdict();
    end
  end
  // ------------------------------------------------------------
  // Table of commands, then reset in mid-write
  // ------------------------------------------------------------
  initial begin
    {sys_rst, cmd_valid, cmd_op, cmd_addr, cmd_code, cmd_enable} = {1'h1, 16'h0};
    {miscompares, compares, cycles} = {32'h0, 32'h0, 32'h0};
    repeat (5) @(negedge ref_clk);
    check({chip_sel_n, first_rank_wr_n, rank_update_n, second_rank_query_n, matrix_reset_n, data_oe, cmd_ready}, 7'h7c);
    sys_rst = 1'h0;
    foreach (rows[i]) run_cmd(rows[i]);
    @(negedge ref_clk);
    {cmd_op, cmd_addr, cmd_code, cmd_enable, cmd_valid} = {CMD_WRITE, 5'h02, 6'h01, 1'h1, 1'h1};
    @(negedge ref_clk);
    cmd_valid = 1'h0;
    repeat (2) @(negedge ref_clk);
    sys_rst = 1'h1;
    @(negedge ref_clk);
    check({chip_sel_n, first_rank_wr_n, rank_update_n, second_rank_query_n, matrix_reset_n, data_oe, cmd_ready}, 7'h7c);
    sys_rst = 1'h0;
    @(negedge ref_clk);
    run_cmd(rows[14]);
    print_verdict();
  end
endmodule : testbench
